// File: hdl/swsp_cfg.svh
// timing counts, command codes and reset values of the single-wire status link
`ifndef SWSP_CFG_SVH
`define SWSP_CFG_SVH
`define SWSP_CLK_HZ 10000000
`define SWSP_STROBE_US 5
`define SWSP_BIT_US 60
`define SWSP_RESET_US 480
`define SWSP_RESET_MIN_US 120
`define SWSP_PRESENCE_US 12
`define SWSP_PROG_US 2500
`define SWSP_US_CYC(us) ((us) * (`SWSP_CLK_HZ / 1000000))
`define SWSP_SAMPLE_CYC (`SWSP_US_CYC(15))
`define SWSP_HOST_SAMPLE_CYC (`SWSP_US_CYC(5))
`define SWSP_PRESENCE_CYC (`SWSP_US_CYC(`SWSP_PRESENCE_US))
`define SWSP_RESET_CYC (`SWSP_US_CYC(`SWSP_RESET_US))
`define SWSP_RESET_MIN_CYC (`SWSP_US_CYC(`SWSP_RESET_MIN_US))
`define SWSP_PROG_MIN_CYC (`SWSP_US_CYC(1000))
`define SWSP_CMD_READ_ID 8'h33
`define SWSP_CMD_SKIP_ID 8'hcc
`define SWSP_CMD_WRITE_MEM 8'h0f
`define SWSP_CMD_PROFILE 8'h99
`define SWSP_CMD_WRITE_STAT 8'h55
`define SWSP_CMD_PROGRAM 8'h5a
`define SWSP_PROFILE_BYTE 8'h55
`define SWSP_STAT_ERASED 8'hff
`define SWSP_STAT_FACTORY 8'h00
`define SWSP_ID_FAMILY 8'h5e
`define SWSP_ID_SERIAL 48'h0123_4567_89ab
`define SWSP_FIFO_DEPTH 8
`endif

// File: hdl/swsp_pkg.sv
// types shared by the single-wire status link ends
package swsp_pkg;
    typedef enum logic [3:0] {
        SWSP_HOST_IDLE = 4'b0001,
        SWSP_HOST_LOW = 4'b0010,
        SWSP_HOST_HOLD = 4'b0100,
        SWSP_HOST_WAIT = 4'b1000
    } swsp_host_state_t;
    typedef enum logic [6:0] {
        SWSP_DEV_WAIT_INIT = 7'b0000001,
        SWSP_DEV_ROM = 7'b0000010,
        SWSP_DEV_FUNC = 7'b0000100,
        SWSP_DEV_ADDR = 7'b0001000,
        SWSP_DEV_DATA = 7'b0010000,
        SWSP_DEV_SEND = 7'b0100000,
        SWSP_DEV_PROG = 7'b1000000
    } swsp_dev_state_t;
    typedef enum logic [2:0] {
        SWSP_OP_RESET = 3'h0,
        SWSP_OP_WRITE = 3'h1,
        SWSP_OP_READ = 3'h2,
        SWSP_OP_PROG = 3'h3
    } swsp_op_t;
endpackage

// File: hdl/swsp_link_if.sv
// shared data line between host and device ends
`timescale 1ns/10ps
interface swsp_link_if;
    logic host_out;
    logic host_oe_n;
    logic host_prog;
    logic dev_out;
    logic dev_oe_n;
    logic line;
    assign line = (!host_oe_n && !host_out) || (!dev_oe_n && !dev_out) ? 1'b0 : 1'b1;
    modport host (output host_out, output host_oe_n, output host_prog, input line);
    modport device (output dev_out, output dev_oe_n, input host_prog, input line);
endinterface

// File: hdl/swsp_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module swsp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // read accept
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;
    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always_ff @(posedge sys_clk)
    begin
        if (do_wr)
            mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule

// File: hdl/swsp_host.sv
// host end: times reset, write, read and program slots from queued operations
`timescale 1ns/10ps
`include "swsp_cfg.svh"
module swsp_host
    import swsp_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset
    swsp_link_if.host link, // data line
    input wire logic op_valid, // operation request
    output logic op_ready, // fifo has room
    input wire logic [2:0] op_code, // reset, write, read or program
    input wire logic [7:0] op_bit, // bit to write, lsb used
    output logic rd_valid, // read or presence result pulse
    output logic rd_bit, // sampled line level
    output logic busy // slot in progress
);
    logic [10:0] head;
    logic head_valid;
    logic take;
    swsp_host_state_t state;
    swsp_op_t cur_op;
    logic cur_bit;
    logic [15:0] timer;
    logic line_s1;
    logic line_s2;
    logic next_op_ready;
    swsp_fifo #(.WIDTH(11), .DEPTH(`SWSP_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(op_valid),
        .in_ready(next_op_ready),
        .in_data({op_code, op_bit}),
        .out_valid(head_valid),
        .out_ready(take),
        .out_data(head)
    );
    assign op_ready = next_op_ready;
    assign take = head_valid && state == SWSP_HOST_IDLE;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
        end
        else
        begin
            line_s1 <= link.line;
            line_s2 <= line_s1;
        end
    end
    // write, read and reset slots open with a low strobe, a program slot drives high; reset holds low 481 us
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= SWSP_HOST_IDLE;
            cur_op <= SWSP_OP_RESET;
            cur_bit <= 1'b1;
            timer <= '0;
            link.host_out <= 1'b1;
            link.host_oe_n <= 1'b1;
            link.host_prog <= 1'b0;
            rd_valid <= 1'b0;
            rd_bit <= 1'b1;
            busy <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            timer <= timer + 1'b1;
            unique case (state)
                SWSP_HOST_IDLE:
                begin
                    busy <= 1'b0;
                    if (take)
                    begin
                        cur_op <= swsp_op_t'(head[10:8]);
                        cur_bit <= head[0];
                        timer <= '0;
                        busy <= 1'b1;
                        state <= SWSP_HOST_LOW;
                        link.host_out <= 1'b0;
                        link.host_oe_n <= 1'b0;
                        link.host_prog <= swsp_op_t'(head[10:8]) == SWSP_OP_PROG;
                        if (swsp_op_t'(head[10:8]) == SWSP_OP_PROG)
                        begin
                            link.host_out <= 1'b1;
                        end
                    end
                end
                SWSP_HOST_LOW:
                begin
                    if (cur_op == SWSP_OP_RESET && timer == 16'(`SWSP_RESET_CYC + 10))
                    begin
                        link.host_oe_n <= 1'b1;
                        timer <= '0;
                        state <= SWSP_HOST_HOLD;
                    end
                    else if (cur_op == SWSP_OP_PROG && timer == 16'(`SWSP_US_CYC(`SWSP_PROG_US)))
                    begin
                        link.host_prog <= 1'b0;
                        link.host_oe_n <= 1'b1;
                        timer <= '0;
                        state <= SWSP_HOST_WAIT;
                    end
                    else if ((cur_op == SWSP_OP_WRITE || cur_op == SWSP_OP_READ)
                        && timer == 16'(`SWSP_US_CYC(`SWSP_STROBE_US)))
                    begin
                        link.host_oe_n <= !(cur_op == SWSP_OP_WRITE && !cur_bit);
                        timer <= '0;
                        state <= SWSP_HOST_HOLD;
                    end
                end
                SWSP_HOST_HOLD:
                begin
                    // sample 10 us into the slot, before the device lets go at 15 us
                    if (cur_op != SWSP_OP_WRITE && timer == 16'(`SWSP_HOST_SAMPLE_CYC))
                    begin
                        rd_bit <= line_s2;
                        rd_valid <= 1'b1;
                    end
                    if (timer == 16'(`SWSP_US_CYC(`SWSP_BIT_US)))
                    begin
                        link.host_oe_n <= 1'b1;
                        timer <= '0;
                        state <= SWSP_HOST_WAIT;
                    end
                end
                SWSP_HOST_WAIT:
                begin
                    if (timer == 16'(`SWSP_US_CYC(10)) && line_s2)
                        state <= SWSP_HOST_IDLE;
                end
                default:
                    state <= SWSP_HOST_IDLE;
            endcase
        end
    end
endmodule

// File: hdl/swsp_device.sv
// device end: slot decoder, command layer, status field programming and crc
`timescale 1ns/10ps
`include "swsp_cfg.svh"
module swsp_device
    import swsp_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset
    swsp_link_if.device link, // data line
    output logic [7:0] stat_addr, // current status address
    output logic [63:0] stat_view, // status field contents
    output logic presence // presence pulse active
);
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
        logic fb;
        fb = crc[0] ^ din;
        crc_step = {fb, crc[7:1]} ^ (fb ? 8'h0c : 8'h00);
    endfunction
    function automatic logic [7:0] crc_bytes(input logic [55:0] data);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = crc_step(c, data[i]);
        crc_bytes = c;
    endfunction
    localparam logic [55:0] ID_LOW = {`SWSP_ID_SERIAL, `SWSP_ID_FAMILY}; // arbitrary serial and family
    localparam logic [63:0] ID_FULL = {crc_bytes(ID_LOW), ID_LOW};
    swsp_dev_state_t state;
    logic line_s1;
    logic line_s2;
    logic line_d;
    logic [15:0] low_cnt;
    logic [15:0] slot_cnt;
    logic in_slot;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic [7:0] crc;
    logic [7:0] cmd;
    logic [1:0] addr_n;
    logic [7:0] data_buf;
    logic [63:0] tx_word;
    logic [6:0] tx_cnt;
    logic tx_verify;
    logic [7:0] stat [8];
    logic drive_low;
    logic [7:0] pres_cnt;
    logic pres_pend;
    logic slot_bit;
    logic slot_done;
    logic [7:0] rx_byte;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
            line_d <= 1'b1;
        end
        else
        begin
            line_s1 <= link.line;
            line_s2 <= line_s1;
            line_d <= line_s2;
        end
    end
    // slot timing: fall starts slot, sample after 15 us
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            low_cnt <= '0;
            slot_cnt <= '0;
            in_slot <= 1'b0;
        end
        else
        begin
            low_cnt <= line_s2 ? '0 : (low_cnt == 16'hffff ? low_cnt : low_cnt + 1'b1);
            // own presence low must not open a slot
            if (line_d && !line_s2 && !link.host_prog && !pres_pend)
            begin
                in_slot <= 1'b1;
                slot_cnt <= '0;
            end
            else if (in_slot)
            begin
                slot_cnt <= slot_cnt + 1'b1;
                if (slot_done)
                    in_slot <= 1'b0;
            end
        end
    end
    assign slot_done = in_slot && slot_cnt == 16'(`SWSP_SAMPLE_CYC);
    assign slot_bit = drive_low ? 1'b0 : line_s2;
    assign rx_byte = {slot_bit, shreg[7:1]};
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            drive_low <= 1'b0;
            link.dev_out <= 1'b1;
            link.dev_oe_n <= 1'b1;
            presence <= 1'b0;
        end
        else
        begin
            drive_low <= (presence || (state == SWSP_DEV_SEND && in_slot && !tx_word[0]));
            link.dev_out <= 1'b0;
            link.dev_oe_n <= !(presence || (state == SWSP_DEV_SEND && in_slot && !tx_word[0]));
            presence <= pres_pend && (line_s2 || pres_cnt != 8'h00) && pres_cnt < 8'(`SWSP_PRESENCE_CYC);
        end
    end
    // command layer and status field
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= SWSP_DEV_WAIT_INIT;
            shreg <= '0;
            bitn <= '0;
            crc <= '0;
            cmd <= '0;
            addr_n <= '0;
            data_buf <= 8'hff;
            tx_word <= '1;
            tx_cnt <= '0;
            tx_verify <= 1'b0;
            stat_addr <= '0;
            pres_pend <= 1'b0;
            pres_cnt <= '0;
            for (int i = 0; i < 7; i++)
                stat[i] <= `SWSP_STAT_ERASED;
            stat[7] <= `SWSP_STAT_FACTORY;
        end
        else if (low_cnt == 16'(`SWSP_RESET_CYC))
        begin
            state <= SWSP_DEV_WAIT_INIT;
            pres_pend <= 1'b1;
            pres_cnt <= '0;
            bitn <= '0;
            cmd <= '0;
        end
        else
        begin
            // count from the release on, whatever the line does then
            if (pres_pend && (line_s2 || pres_cnt != 8'h00))
            begin
                pres_cnt <= pres_cnt + 1'b1;
                if (pres_cnt == 8'(`SWSP_PRESENCE_CYC))
                begin
                    pres_pend <= 1'b0;
                    state <= SWSP_DEV_ROM;
                    crc <= 8'h00;
                end
            end
            if (state == SWSP_DEV_PROG && link.host_prog)
            begin
                stat[stat_addr[2:0]] <= stat[stat_addr[2:0]] & data_buf;
                tx_word <= {56'hff_ffff_ffff_ffff, stat[stat_addr[2:0]] & data_buf};
                tx_cnt <= 7'd8;
                tx_verify <= 1'b1;
                state <= SWSP_DEV_SEND;
            end
            if (slot_done)
            begin
                unique case (state)
                    SWSP_DEV_SEND:
                    begin
                        tx_word <= {1'b1, tx_word[63:1]};
                        tx_cnt <= tx_cnt - 1'b1;
                        if (tx_cnt == 7'd1 && tx_verify)
                        begin
                            stat_addr <= stat_addr + 1'b1;
                            crc <= stat_addr + 1'b1;
                            tx_verify <= 1'b0;
                            bitn <= '0;
                            state <= SWSP_DEV_DATA;
                        end
                        else if (tx_cnt == 7'd1)
                        begin
                            bitn <= '0;
                            state <= (cmd == `SWSP_CMD_WRITE_STAT) ? SWSP_DEV_FUNC : SWSP_DEV_WAIT_INIT;
                        end
                    end
                    SWSP_DEV_WAIT_INIT, SWSP_DEV_PROG:
                    begin
                    end
                    default:
                    begin
                        shreg <= rx_byte;
                        bitn <= bitn + 1'b1;
                        crc <= crc_step(crc, slot_bit);
                        if (bitn == 3'd7)
                        begin
                            unique case (state)
                                SWSP_DEV_ROM:
                                begin
                                    crc <= 8'h00;
                                    if (rx_byte == `SWSP_CMD_READ_ID)
                                    begin
                                        tx_word <= ID_FULL;
                                        tx_cnt <= 7'd64;
                                        cmd <= rx_byte;
                                        state <= SWSP_DEV_SEND;
                                    end
                                    else
                                        state <= (rx_byte == `SWSP_CMD_SKIP_ID) ? SWSP_DEV_FUNC : SWSP_DEV_WAIT_INIT;
                                end
                                SWSP_DEV_FUNC:
                                begin
                                    cmd <= rx_byte;
                                    addr_n <= '0;
                                    if (rx_byte == `SWSP_CMD_PROFILE)
                                    begin
                                        tx_word <= {56'hff_ffff_ffff_ffff, `SWSP_PROFILE_BYTE};
                                        tx_cnt <= 7'd8;
                                        state <= SWSP_DEV_SEND;
                                    end
                                    else if (cmd == `SWSP_CMD_WRITE_STAT && rx_byte == `SWSP_CMD_PROGRAM)
                                    begin
                                        cmd <= `SWSP_CMD_WRITE_STAT;
                                        state <= SWSP_DEV_PROG;
                                    end
                                    else if (rx_byte == `SWSP_CMD_WRITE_STAT || rx_byte == `SWSP_CMD_WRITE_MEM)
                                    begin
                                        crc <= crc_step(crc, slot_bit);
                                        state <= SWSP_DEV_ADDR;
                                    end
                                    else
                                        state <= SWSP_DEV_WAIT_INIT;
                                end
                                SWSP_DEV_ADDR:
                                begin
                                    addr_n <= addr_n + 1'b1;
                                    if (addr_n == 2'd0)
                                        stat_addr <= rx_byte;
                                    else
                                        state <= SWSP_DEV_DATA;
                                end
                                SWSP_DEV_DATA:
                                begin
                                    data_buf <= rx_byte;
                                    tx_word <= {56'hff_ffff_ffff_ffff, crc_step(crc, slot_bit)};
                                    tx_cnt <= 7'd8;
                                    state <= SWSP_DEV_SEND;
                                end
                                default:
                                    state <= SWSP_DEV_WAIT_INIT;
                            endcase
                        end
                    end
                endcase
            end
        end
    end
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            stat_view[i*8 +: 8] = stat[i];
    end
endmodule

// File: verif/swsp_link_props.sv
// concurrent checks on the shared data line
`timescale 1ns/10ps
module swsp_link_props (
    input wire logic sys_clk, // clock
    input wire logic reset, // async reset
    input wire logic host_out, // host level
    input wire logic host_oe_n, // host enable
    input wire logic host_prog, // program pulse
    input wire logic dev_out, // device level
    input wire logic dev_oe_n, // device enable
    input wire logic line // resolved line
);
    logic [15:0] low_cnt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // length of the current host low
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            low_cnt <= 16'h0000;
        else if (!host_oe_n && !host_out)
            low_cnt <= low_cnt + 16'h0001;
        else
            low_cnt <= 16'h0000;
    end
    dev_pull_low_a: assert property (!dev_oe_n |-> !dev_out)
        else $error("device drives line high");
    dev_release_a: assert property ($fell(dev_oe_n) |-> ##[1:300] $rose(dev_oe_n))
        else $error("device holds line too long");
    host_strobe_a: assert property ($fell(host_oe_n) |-> !host_oe_n throughout (##48 1'b1))
        else $error("host strobe too short");
    host_recover_a: assert property ($rose(host_oe_n) |-> host_oe_n [*8])
        else $error("host slot recovery too short");
    reset_len_a: assert property ($rose(host_oe_n) && low_cnt > 16'd700 |-> low_cnt >= 16'd4800)
        else $error("reset low too short");
    presence_a: assert property ($rose(host_oe_n) && low_cnt >= 16'd4800 |-> ##[1:1000] !dev_oe_n)
        else $error("no presence after reset");
    dev_quiet_a: assert property (low_cnt > 16'd700 |-> dev_oe_n)
        else $error("device drives during reset low");
    prog_free_a: assert property (host_prog |-> host_out && dev_oe_n)
        else $error("line driven during program pulse");
    line_idle_a: assert property (host_oe_n && dev_oe_n |-> line)
        else $error("released line not high");
endmodule

// File: verif/tb_single_wire_status_program_link.sv
// testbench: host and device ends joined, status programming walked through
`timescale 1ns/10ps
module tb_single_wire_status_program_link;
    import swsp_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic op_valid = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [7:0] op_bit = 8'h00;
    logic op_ready, rd_valid, rd_bit, busy, presence;
    logic [7:0] stat_addr;
    logic [63:0] stat_view;
    logic rx_q[$];
    int error_cnt = 0;
    int compares = 0;
    swsp_link_if link ();
    swsp_host u_swsp_host (.sys_clk(sys_clk), .reset(reset), .link(link.host), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_bit(op_bit), .rd_valid(rd_valid), .rd_bit(rd_bit), .busy(busy));
    swsp_device u_swsp_device (.sys_clk(sys_clk), .reset(reset), .link(link.device), .stat_addr(stat_addr),
        .stat_view(stat_view), .presence(presence));
    swsp_link_props u_swsp_link_props (.sys_clk(sys_clk), .reset(reset), .host_out(link.host_out),
        .host_oe_n(link.host_oe_n), .host_prog(link.host_prog), .dev_out(link.dev_out),
        .dev_oe_n(link.dev_oe_n), .line(link.line));
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (rd_valid === 1'b1)
            rx_q.push_back(rd_bit);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // lsb-first serial crc, feedback taps x8+x5+x4+1
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
        return r;
    endfunction
    // holds the request until taken; op_valid stays up for the next call
    task automatic put_op(input logic [2:0] code, input logic [7:0] b);
        op_valid <= 1'b1;
        op_code <= code;
        op_bit <= b;
        for (int n = 0; n < 20000; n++)
        begin
            @(negedge sys_clk);
            if (op_ready === 1'b1)
                break;
        end
        @(posedge sys_clk);
    endtask
    task automatic get_bits(input int n, output logic [7:0] v);
        v = 8'h00;
        op_valid <= 1'b0;
        for (int k = 0; k < 40000 && rx_q.size() < n; k++)
            @(negedge sys_clk);
        for (int i = 0; i < n && rx_q.size() > 0; i++)
            v[i] = rx_q.pop_front();
        while (busy !== 1'b0)
            @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            put_op(SWSP_OP_WRITE, {7'h00, b[i]});
    endtask
    task automatic read_byte(output logic [7:0] v);
        for (int i = 0; i < 8; i++)
            put_op(SWSP_OP_READ, 8'h00);
        get_bits(8, v);
    endtask
    task automatic bus_reset();
        logic [7:0] v;
        put_op(SWSP_OP_RESET, 8'h00);
        op_valid <= 1'b0;
        for (int k = 0; k < 6000 && presence !== 1'b1; k++)
            @(negedge sys_clk);
        check(presence, 1'b1);
        get_bits(1, v);
        check(v[0], 1'b0);
    endtask
    task automatic t_status_write();
        logic [7:0] v;
        logic [7:0] crc;
        bus_reset();
        send_byte(`SWSP_CMD_SKIP_ID);
        send_byte(`SWSP_CMD_WRITE_STAT);
        send_byte(8'h06);
        send_byte(8'h00);
        send_byte(8'h3c);
        crc = crc8(crc8(crc8(crc8(8'h00, 8'h55), 8'h06), 8'h00), 8'h3c);
        read_byte(v);
        check(v, crc);
        send_byte(`SWSP_CMD_PROGRAM);
        put_op(SWSP_OP_PROG, 8'h00);
        read_byte(v);
        check(v, 8'h3c);
        check(stat_view, 64'h003c_ffff_ffff_ffff);
        check(stat_addr, 8'h07);
    endtask
    task automatic t_next_byte();
        logic [7:0] v;
        send_byte(8'h81);
        read_byte(v);
        check(v, crc8(8'h07, 8'h81));
    endtask
    task automatic t_abort();
        bus_reset();
        check(stat_view, 64'h003c_ffff_ffff_ffff);
    endtask
    task automatic end_of_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #11000000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        check(stat_view, 64'h00ff_ffff_ffff_ffff);
        t_status_write();
        t_next_byte();
        t_abort();
        end_of_test();
    end
endmodule
